// ==== rtl/field_meter_pkg.sv ====
// shared constants and types of the field meter front-panel controller
`default_nettype none
package field_meter_pkg;
    // ============================================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int NRANGE = 4;
    localparam int ZERO_ALL_S = 10;
    localparam int SETTLE_CYC = CLK_HZ / NRANGE * ZERO_ALL_S;
    localparam int DEB_MS = 10;
    localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
    localparam int BOTH_MS = 100;
    localparam int BOTH_CYC = CLK_HZ / 1000 * BOTH_MS;
    localparam int ZMSG_MS = 1000;
    localparam int ZMSG_CYC = CLK_HZ / 1000 * ZMSG_MS;
    localparam int RMSG_S = 1;
    localparam int RMSG_CYC = CLK_HZ * RMSG_S;
    localparam int BOOT_S = 2;
    localparam int BOOT_CYC = CLK_HZ * BOOT_S;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int TW = 25;
    // ============================================================
    // readings in signed counts of 0.1 mT, full scales 0.3/0.6/1.2/3.0 T
    localparam int RW = 18;
    localparam logic [NRANGE-1:0][RW-1:0] FS =
        {18'h07530, 18'h02ee0, 18'h01770, 18'h00bb8};
    localparam logic [1:0] TOP_RANGE = 2'h3;
    localparam int UP_PCT = 105;
    localparam int DN_PCT = 95;
    localparam int OVR_PCT = 106;
    localparam int PCT_DIV = 100;
    function automatic logic [RW-1:0] pct_of(input logic [RW-1:0] fs, input int pct);
        return RW'((32'(fs) * pct) / PCT_DIV);
    endfunction
    // ============================================================
    // pins, registers, commands
    localparam int P_MODE = 0;
    localparam int P_RANGE = 1;
    localparam int P_SINGLE = 2;
    localparam int P_UNIT = 3;
    localparam int P_FILT = 4;
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_FILT = 8'h08;
    localparam logic [7:0] A_RATE = 8'h0c;
    localparam logic [7:0] A_DISP = 8'h10;
    localparam logic [7:0] A_OFS = 8'h20;
    localparam logic [7:0] FILT_DEF = 8'h08;
    localparam logic [7:0] RATE_DEF = 8'h1e;
    localparam int CMD_MODE = 0;
    localparam int CMD_RANGE = 1;
    localparam int CMD_BOTH = 2;
    typedef enum logic [1:0] {M_FIELD_AUTO = 2'b00, M_HOLD_MAN = 2'b01,
        M_HOLD_AUTO = 2'b10, M_FIELD_MAN = 2'b11} mode_e;
    typedef enum logic [2:0] {Z_INIT = 3'b000, Z_BOOT = 3'b001, Z_RUN = 3'b010,
        Z_SETTLE = 3'b011, Z_TAKE = 3'b100, Z_MSG = 3'b101, Z_WIPE = 3'b110,
        Z_STRAP = 3'b111} seq_e;
    typedef enum logic [1:0] {K_IDLE = 2'b00, K_WIN = 2'b01, K_BOTH = 2'b10,
        K_ONE = 2'b11} key_e;
    typedef struct packed {logic valid; logic [RW-1:0] raw; logic [RW-1:0] filt;} sample_s;
    typedef struct packed {logic [RW-1:0] value; logic minus; logic over;
        logic zero_msg; logic reset_msg; logic boot_msg; logic dp; logic hold;
        logic unit_g; logic unit_t; logic [NRANGE-1:0] rng;} disp_s;
    typedef struct packed {logic we; logic [1:0] idx; logic [RW-1:0] data;} nv_s;
endpackage
`default_nettype wire

// ==== rtl/field_meter_ctrl.sv ====
// front-panel mode, range, zero and peak control of the field meter
// ============================================================
`timescale 1ns/1ps
`default_nettype none
module field_meter_ctrl
    import field_meter_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC,
    parameter int DEB = DEB_CYC,
    parameter int WIN = BOTH_CYC,
    parameter int ZMSG = ZMSG_CYC,
    parameter int RMSG = RMSG_CYC,
    parameter int BOOT = BOOT_CYC,
    parameter int BLINK = BLINK_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic key_mode_n,
    input wire logic key_range_n,
    input wire logic probe_single,
    input wire logic unit_gauss,
    input wire logic filter_on,
    input wire sample_s smp,
    input wire logic [NRANGE-1:0][RW-1:0] nv_rd,
    output nv_s nv,
    output disp_s disp,
    output logic [7:0] filt_j,
    output logic [7:0] rate
);
    function automatic logic is_auto(input mode_e m);
        return m == M_FIELD_AUTO || m == M_HOLD_AUTO;
    endfunction
    function automatic logic is_hold(input mode_e m);
        return m == M_HOLD_MAN || m == M_HOLD_AUTO;
    endfunction

    // ============================================================
    // pin synchronisers, keys inverted to active high
    logic [4:0] pin_raw, s1_q, s2_q;
    assign pin_raw = {filter_on, unit_gauss, probe_single, ~key_range_n, ~key_mode_n};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
        end
    end

    // ============================================================
    // key debouncers: level accepted after DEB stable cycles
    logic [1:0] kdb;
    for (genvar i = 0; i < 2; i++)
    begin : g_deb
        logic lvl_q, lvl_d;
        logic [TW-1:0] cnt_q, cnt_d;
        always_comb
        begin
            lvl_d = lvl_q;
            cnt_d = '0;
            if (s2_q[i] != lvl_q)
            begin
                cnt_d = cnt_q + 1'h1;
                if (cnt_q == TW'(DEB - 1))
                begin
                    lvl_d = s2_q[i];
                    cnt_d = '0;
                end
            end
        end
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                lvl_q <= 1'h0;
                cnt_q <= '0;
            end
            else
            begin
                lvl_q <= lvl_d;
                cnt_q <= cnt_d;
            end
        end
        assign kdb[i] = lvl_q;
    end

    // ============================================================
    // key combiner: second press inside WIN makes a combined command
    key_e kst_q, kst_d;
    logic first_q, first_d;
    logic [TW-1:0] kt_q, kt_d;
    logic ev_mode, ev_range, ev_both;
    always_comb
    begin
        kst_d = kst_q;
        first_d = first_q;
        kt_d = kt_q;
        ev_mode = 1'h0;
        ev_range = 1'h0;
        ev_both = 1'h0;
        case (kst_q)
            K_IDLE:
                if (kdb != 2'h0)
                begin
                    kst_d = (kdb == 2'h3) ? K_BOTH : K_WIN;
                    first_d = kdb[P_RANGE];
                    kt_d = '0;
                end
            K_WIN:
                if (kdb == 2'h3)
                    kst_d = K_BOTH;
                else if (!kdb[first_q] || kt_q == TW'(WIN - 1))
                begin
                    ev_mode = !first_q;
                    ev_range = first_q;
                    kst_d = kdb[first_q] ? K_ONE : K_IDLE;
                end
                else
                    kt_d = kt_q + 1'h1;
            K_BOTH:
                if (kdb == 2'h0)
                begin
                    ev_both = 1'h1;
                    kst_d = K_IDLE;
                end
            K_ONE:
                if (kdb == 2'h0)
                    kst_d = K_IDLE;
            default:
                kst_d = K_IDLE;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            kst_q <= K_IDLE;
            first_q <= 1'h0;
            kt_q <= '0;
        end
        else
        begin
            kst_q <= kst_d;
            first_q <= first_d;
            kt_q <= kt_d;
        end
    end

    // ============================================================
    // core: modes, ranging, zeroing, peak, display and register bus
    seq_e seq_q, seq_d;
    mode_e mode_q, mode_d;
    logic [1:0] range_q, range_d;
    logic [TW-1:0] tmr_q, tmr_d, bcnt_q, bcnt_d;
    logic [NRANGE-1:0][RW-1:0] ofs_q, ofs_d;
    logic [RW-1:0] peak_q, peak_d, src, corr, mag, pmag;
    logic over_q, over_d, blink_q, blink_d, rmsg_q, rmsg_d;
    logic [7:0] filt_q, filt_d, rate_q, rate_d, wa_q, wa_d;
    logic wp_q, wp_d, acc, auto_on, hold_on, single, evm, evr, evb;
    logic [31:0] rdat_q, rdat_d;
    nv_s nv_q, nv_d;
    disp_s disp_q, disp_d;
    assign auto_on = is_auto(mode_q);
    assign hold_on = is_hold(mode_q);
    assign single = s2_q[P_SINGLE];
    assign src = s2_q[P_FILT] ? smp.filt : smp.raw;
    assign corr = src - ofs_q[range_q];
    assign mag = corr[RW-1] ? RW'(-corr) : corr;
    assign pmag = peak_q[RW-1] ? RW'(-peak_q) : peak_q;
    // only whole-word NONSEQ or SEQ transfers inside the low 256 bytes are decoded
    assign acc = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[31:8] == 24'h0;
    assign evm = ev_mode || (wp_q && wa_q == A_CMD && hwdata[CMD_MODE]);
    assign evr = ev_range || (wp_q && wa_q == A_CMD && hwdata[CMD_RANGE]);
    assign evb = ev_both || (wp_q && wa_q == A_CMD && hwdata[CMD_BOTH]);

    always_comb
    begin
        seq_d = seq_q;
        mode_d = mode_q;
        range_d = range_q;
        tmr_d = tmr_q;
        ofs_d = ofs_q;
        peak_d = peak_q;
        over_d = over_q;
        rmsg_d = rmsg_q;
        filt_d = filt_q;
        rate_d = rate_q;
        nv_d = nv_q;
        nv_d.we = 1'h0;
        wp_d = acc && hwrite;
        wa_d = acc ? haddr[7:0] : wa_q;
        rdat_d = rdat_q;
        // blink timebase for decimal point and zero message
        blink_d = blink_q;
        bcnt_d = bcnt_q + 1'h1;
        if (bcnt_q == TW'(BLINK - 1))
        begin
            bcnt_d = '0;
            blink_d = !blink_q;
        end
        // register writes land in the data phase
        if (wp_q && wa_q == A_FILT)
            filt_d = hwdata[7:0];
        if (wp_q && wa_q == A_RATE)
            rate_d = hwdata[7:0];
        // in autorange only the top range can stay over
        if (smp.valid)
        begin
            over_d = mag > pct_of(FS[(auto_on && !single) ? TOP_RANGE : range_q], OVR_PCT);
            if (hold_on && peak_q != '0 && corr[RW-1] != peak_q[RW-1])
                peak_d = corr;
            else if (hold_on && mag > pmag)
                peak_d = corr;
        end
        case (seq_q)
            Z_INIT:
            begin
                ofs_d = nv_rd;
                tmr_d = TW'(BOOT - 1);
                seq_d = Z_BOOT;
            end
            Z_BOOT:
                if (tmr_q == '0)
                    seq_d = kdb[P_RANGE] ? Z_STRAP : Z_RUN;
                else
                    tmr_d = tmr_q - 1'h1;
            Z_STRAP:
                if (!kdb[P_RANGE])
                begin
                    seq_d = Z_WIPE;
                    tmr_d = '0;
                end
            Z_WIPE:
            begin
                ofs_d[tmr_q[1:0]] = '0;
                nv_d = '{we: 1'h1, idx: tmr_q[1:0], data: '0};
                filt_d = FILT_DEF;
                rate_d = RATE_DEF;
                tmr_d = tmr_q + 1'h1;
                if (tmr_q[1:0] == TOP_RANGE)
                begin
                    seq_d = Z_MSG;
                    rmsg_d = 1'h1;
                    tmr_d = TW'(RMSG - 1);
                end
            end
            Z_RUN:
            begin
                if (evm && !over_q)
                begin
                    mode_d = mode_e'(mode_q + 2'h1);
                    if (mode_q == M_FIELD_AUTO)
                        peak_d = '0;
                end
                if (evr && !auto_on && !single)
                    range_d = range_q + 2'h1;
                if (evb && !over_q)
                begin
                    if (hold_on)
                        peak_d = '0;
                    else if (auto_on && !single)
                    begin
                        range_d = '0;
                        tmr_d = TW'(SETTLE - 1);
                        seq_d = Z_SETTLE;
                    end
                    else
                        seq_d = Z_TAKE;
                end
                else if (smp.valid && auto_on && !single)
                begin
                    if (range_q != TOP_RANGE && mag >= pct_of(FS[range_q], UP_PCT))
                        range_d = range_q + 2'h1;
                    else if (range_q != '0 && mag <= pct_of(FS[range_q - 2'h1], DN_PCT))
                        range_d = range_q - 2'h1;
                end
            end
            Z_SETTLE:
                if (tmr_q == '0)
                    seq_d = Z_TAKE;
                else
                    tmr_d = tmr_q - 1'h1;
            Z_TAKE:
                if (smp.valid)
                begin
                    ofs_d[range_q] = smp.raw;
                    nv_d = '{we: 1'h1, idx: range_q, data: smp.raw};
                    if (auto_on && !single && range_q != TOP_RANGE)
                    begin
                        range_d = range_q + 2'h1;
                        tmr_d = TW'(SETTLE - 1);
                        seq_d = Z_SETTLE;
                    end
                    else
                    begin
                        tmr_d = TW'(ZMSG - 1);
                        rmsg_d = 1'h0;
                        seq_d = Z_MSG;
                    end
                end
            Z_MSG:
                if (tmr_q == '0)
                begin
                    seq_d = Z_RUN;
                    rmsg_d = 1'h0;
                end
                else
                    tmr_d = tmr_q - 1'h1;
            default:
                seq_d = Z_RUN;
        endcase
        // read data is captured in the address phase, so no wait state
        if (acc && !hwrite)
        begin
            rdat_d = '0;
            case (haddr[7:0])
                A_STATUS:
                    rdat_d = 32'({seq_q, over_q, single, auto_on, hold_on, range_q, mode_q});
                A_FILT:
                    rdat_d = 32'(filt_q);
                A_RATE:
                    rdat_d = 32'(rate_q);
                A_DISP:
                    rdat_d = 32'($signed(disp_q.value));
                default:
                    if (haddr[7:4] == A_OFS[7:4] && haddr[1:0] == 2'h0)
                        rdat_d = 32'($signed(ofs_q[haddr[3:2]]));
            endcase
        end
        // display image; value frozen between samples
        disp_d.value = is_hold(mode_d) ? peak_d : (smp.valid ? corr : disp_q.value);
        disp_d.minus = disp_d.value[RW-1];
        disp_d.over = over_d;
        disp_d.zero_msg = ((seq_d == Z_SETTLE || seq_d == Z_TAKE) && (blink_d || !auto_on))
            || (seq_d == Z_MSG && !rmsg_d);
        disp_d.reset_msg = seq_d == Z_MSG && rmsg_d;
        disp_d.boot_msg = seq_d == Z_BOOT;
        disp_d.dp = is_auto(mode_d) && blink_d;
        disp_d.hold = is_hold(mode_d);
        disp_d.unit_g = s2_q[P_UNIT];
        disp_d.unit_t = !s2_q[P_UNIT];
        disp_d.rng = NRANGE'(1) << range_d;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            seq_q <= Z_INIT;
            mode_q <= M_FIELD_AUTO;
            range_q <= '0;
            tmr_q <= '0;
            bcnt_q <= '0;
            ofs_q <= '0;
            peak_q <= '0;
            over_q <= 1'h0;
            blink_q <= 1'h0;
            rmsg_q <= 1'h0;
            filt_q <= FILT_DEF;
            rate_q <= RATE_DEF;
            wa_q <= '0;
            wp_q <= 1'h0;
            rdat_q <= '0;
            nv_q <= '0;
            disp_q <= '0;
        end
        else
        begin
            seq_q <= seq_d;
            mode_q <= mode_d;
            range_q <= range_d;
            tmr_q <= tmr_d;
            bcnt_q <= bcnt_d;
            ofs_q <= ofs_d;
            peak_q <= peak_d;
            over_q <= over_d;
            blink_q <= blink_d;
            rmsg_q <= rmsg_d;
            filt_q <= filt_d;
            rate_q <= rate_d;
            wa_q <= wa_d;
            wp_q <= wp_d;
            rdat_q <= rdat_d;
            nv_q <= nv_d;
            disp_q <= disp_d;
        end
    end
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign hrdata = rdat_q;
    assign nv = nv_q;
    assign disp = disp_q;
    assign filt_j = filt_q;
    assign rate = rate_q;

    // ============================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic run;
    assign run = seq_q == Z_RUN;
    sequence s_zero_go;
        run && evb && !over_q && !hold_on && auto_on && !single;
    endsequence
    sequence s_first_settle;
        seq_q == Z_SETTLE && range_q == 2'h0 && tmr_q == TW'(SETTLE - 1);
    endsequence
    a_auto_zero: assert property (s_zero_go |=> s_first_settle)
        else $error("auto zero did not start at lowest range");
    a_single_zero: assert property (run && evb && !over_q && !hold_on && single
        |=> seq_q == Z_TAKE && $stable(range_q))
        else $error("single probe zero stepped ranges");
    a_range_step: assert property (run && evr && !auto_on && !single
        |=> range_q == $past(range_q) + 2'h1)
        else $error("range key did not advance");
    a_range_lock: assert property (run && evr && !evb && (auto_on || single)
        && !smp.valid |=> $stable(range_q))
        else $error("range key acted while locked");
    a_mode_step: assert property (run && evm && !over_q
        |=> mode_q == mode_e'($past(mode_q) + 2'h1))
        else $error("mode key did not advance");
    a_over_lock: assert property (run && over_q && (evm || evb)
        |=> $stable(mode_q) && seq_q == Z_RUN)
        else $error("key acted during over-range");
    a_auto_up: assert property (run && auto_on && !single && smp.valid && !evb
        && range_q != TOP_RANGE && mag >= pct_of(FS[range_q], UP_PCT)
        |=> range_q == $past(range_q) + 2'h1)
        else $error("autorange did not step up");
    a_mode_leds: assert property (disp.hold == hold_on
        && disp.dp == (auto_on && blink_q))
        else $error("hold or decimal indicator wrong");
    a_wipe_all: assert property ($rose(seq_q == Z_WIPE)
        |-> ##4 (ofs_q == '0 && disp.reset_msg && filt_q == FILT_DEF))
        else $error("defaults reload incomplete");
    a_boot_auto: assert property (seq_q == Z_BOOT |-> mode_q == M_FIELD_AUTO)
        else $error("power-up mode not field autorange");
    a_zero_take: assert property (seq_q == Z_TAKE && smp.valid
        |=> ofs_q[$past(range_q)] == $past(smp.raw) && nv.we)
        else $error("zero did not capture raw reading");
endmodule
`default_nettype wire

// ==== dv/field_meter_operator.sv ====
// operator keys and field front end model
`timescale 1ns/1ps
`default_nettype none
module field_meter_operator
    import field_meter_pkg::*;
(
    input wire logic hclk,
    output logic key_mode_n,
    output logic key_range_n,
    output sample_s smp
);
    // ========
    // keys rest released (pulled up)
    initial
    begin
        key_mode_n = 1'b1;
        key_range_n = 1'b1;
        smp = '0;
    end
    task automatic keys(input logic [1:0] k);
        @(posedge hclk);
        key_mode_n <= !k[0];
        key_range_n <= !k[1];
    endtask
    // second key lands 3 cycles late, well inside the window
    task automatic press(input logic [1:0] k);
        keys({k[1] & !k[0], k[0]});
        repeat (2) @(posedge hclk);
        keys(k);
        repeat (8) @(posedge hclk);
        keys(2'b00);
        repeat (16) @(posedge hclk);
    endtask
    // data goes stale off valid so nothing leans on old values
    task automatic feed(input logic [RW-1:0] v);
        @(posedge hclk);
        smp <= '{valid: 1'b1, raw: v, filt: v};
        @(posedge hclk);
        smp <= '{valid: 1'b0, raw: ~v, filt: ~v};
        repeat (3) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// ==== dv/field_meter_mode_range_control_bench.sv ====
// self-checking bench of the field meter controller
`timescale 1ns/1ps
`default_nettype none
module field_meter_mode_range_control_bench
    import field_meter_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dph = 0, unit_gauss = 0;
    logic probe_single = 0, filter_on = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, seed = 32'd81654;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [NRANGE-1:0][RW-1:0] nv_rd = '0;
    logic hreadyout, hresp, key_mode_n, key_range_n;
    logic [7:0] filt_j, rate;
    sample_s smp;
    nv_s nv;
    disp_s disp;
    int num_errors = 0, n_checks = 0;
    logic [63:0] q[$], nt;
    // ========
    // short counts keep the run brief
    field_meter_ctrl #(.SETTLE(20), .DEB(3), .WIN(10), .ZMSG(10), .RMSG(10), .BOOT(10),
        .BLINK(4)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_mode_n(key_mode_n),
        .key_range_n(key_range_n), .probe_single(probe_single), .unit_gauss(unit_gauss),
        .filter_on(filter_on), .smp(smp), .nv_rd(nv_rd), .nv(nv), .disp(disp), .filt_j(filt_j),
        .rate(rate));
    field_meter_operator op (.hclk(hclk), .key_mode_n(key_mode_n),
        .key_range_n(key_range_n), .smp(smp));
    always #50 hclk = ~hclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // single word transfer, waits on the slave's ready each phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        dph <= !w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        dph <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        q.push_back({m, e});
        ahb(1'b0, a, '0);
    endtask
    // watcher pairs each read data phase with the oldest note
    always @(posedge hclk)
        if (dph && hreadyout)
        begin
            nt = q.pop_front();
            chk(hrdata & nt[63:32], nt[31:0]);
        end
    // reset with keys k held until boot has ended
    task automatic rst(input logic [1:0] k);
        op.keys(k);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (14) @(posedge hclk);
        op.keys(2'b00);
        repeat (25) @(posedge hclk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles needed
    initial
    begin
        #(30000 * 100);
        num_errors++;
        conclude();
    end
    // ========
    // main sequence
    initial
    begin
        for (int i = 0; i < NRANGE; i++) nv_rd[i] = RW'(rnd() & 32'h1ffff);
        rst(2'b00);
        rd(A_STATUS, 32'hff, 32'h20);
        rd(A_OFS + 8'h04, '1, {14'h0, nv_rd[1]});
        unit_gauss <= rnd() & 32'h1;
        ahb(1'b1, A_FILT, 32'h33);
        rd(A_FILT, 32'hff, 32'h33);
        chk(32'(disp.unit_g), 32'(unit_gauss));
        chk(32'(disp.unit_t), 32'(!unit_gauss));
        $display("test boot ends");
        rst(2'b10);
        for (int i = 0; i < NRANGE; i++) rd(A_OFS + 8'(4 * i), '1, 32'h0);
        rd(A_FILT, 32'hff, 32'h08);
        rd(A_RATE, 32'hff, 32'h1e);
        $display("test reload ends");
        op.feed(18'd3149);
        rd(A_STATUS, 32'hff, 32'h20);
        op.feed(18'd3150);
        rd(A_STATUS, 32'hff, 32'h24);
        op.feed(18'd2851);
        rd(A_STATUS, 32'hff, 32'h24);
        op.feed(18'd2850);
        rd(A_STATUS, 32'hff, 32'h20);
        ahb(1'b1, A_CMD, 32'h2);
        rd(A_STATUS, 32'hff, 32'h20);
        $display("test autorange ends");
        op.press(2'b01);
        rd(A_STATUS, 32'hff, 32'h11);
        chk(32'(disp.hold), 32'h1);
        op.press(2'b01);
        rd(A_STATUS, 32'hff, 32'h32);
        op.press(2'b01);
        rd(A_STATUS, 32'hff, 32'h03);
        for (int i = 1; i <= NRANGE; i++)
        begin
            op.press(2'b10);
            rd(A_STATUS, 32'hff, 32'h03 | 32'((i % 4) << 2));
            chk(32'(disp.rng), 32'(1 << (i % 4)));
        end
        $display("test keys ends");
        op.press(2'b11);
        op.feed(18'd100);
        repeat (20) @(posedge hclk);
        rd(A_OFS, '1, 32'd100);
        op.feed(18'd40);
        rd(A_DISP, '1, 32'hffffffc4);
        chk(32'(disp.minus), 32'h1);
        $display("test zero ends");
        // range 0 carries an offset of 100, so 3281 reads 3181, just above 106%
        op.feed(18'd3281);
        rd(A_STATUS, 32'hff, 32'h83);
        op.press(2'b01);
        rd(A_STATUS, 32'hff, 32'h83);
        ahb(1'b1, A_CMD, 32'h2);
        op.feed(18'd3281);
        rd(A_STATUS, 32'hff, 32'h07);
        $display("test over ends");
        repeat (4) @(posedge hclk);
        conclude();
    end
endmodule
`default_nettype wire
